// >>> logic/tb_diag_regs.sv
/*
  translation-buffer control/status, backplane-bus history silo and bus error
  register, reached by the microcoded data path over the internal data bus.
  assumes the data path gives single-cycle read/write strobes with an address,
  and that the tb array, checkers and bus interface report events as pulses.
*/
// Function
// - tb write port is write-only; va is placed beforehand by the writer, pte comes with the write.
// - tb write: both if set, else hit group, else forced group, else random.
// - mapping disabled: traps off, virtual address used as physical.
// - four-bit forced parity code picks group, address/data and byte to corrupt.
// - bits 6,7 show latched group zero and group one match outputs.
// - bits 8-15 record last non-nop memory request details.
// - bits 16,17 force no-match and disable parity checks on that group.
// - bits 19:18 pick written group: random, zero, one; 11 not used.
// - bit 20 sends tb writes to both groups.
// - status bits 0-3 describe the latest prefetch address load.
// - invalid bit sets on page crossing or flush, clears on load.
// - bit 6 shows the group last written.
// - parity trap flag sets on trap request, any write clears it.
// - bits 9-20 load checker results on qualified parity error; write clears.
// - silo keeps last 16 bus cycles, writes and advances each cycle.
// - during fault silo frozen; counter advances only on software read.
// - first entry after fault clears carries bit 31 set.
// - silo 21-18 take data 31-28 on command tag, else mask lines.
// - corrected and substituted data bits, with enable, request interrupt.
// - timeout bit sets on cpu bus timeout, interrupt while set.
// - timeout status bits encode the timeout cause.
// - error confirmation bit sets on cpu command error, interrupt while set.
// - writing one to bit 12 clears bits 12, 11, 10, 8 and 2.
// - bit 2 sets on a second cpu error while one is recorded.
`default_nettype none

module tb_diag_regs
  import tb_diag_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // internal data bus register access
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // translation buffer array side
  input  wire logic        i_g0_match,
  input  wire logic        i_g1_match,
  output logic             o_tb_we_g0,
  output logic             o_tb_we_g1,
  output logic      [31:0] o_tb_pte,
  output logic             o_mapping_enable,
  output logic             o_force_miss_g0,
  output logic             o_force_miss_g1,
  output logic      [11:0] o_force_par_err,
  // memory requests and prefetch address register
  input  wire logic        i_mem_req,
  input  wire logic [7:0]  i_mem_req_info,
  input  wire logic        i_pfa_load,
  input  wire logic [3:0]  i_pfa_info,
  input  wire logic        i_pfa_cross_page,
  input  wire logic        i_flush,
  input  wire logic        i_par_trap_req,
  input  wire logic        i_par_err,
  input  wire logic        i_par_traps_on,
  input  wire logic [11:0] i_par_checkers,
  // backplane bus signals
  input  wire logic        i_bus_fault,
  input  wire logic        i_bus_interlock,
  input  wire logic [4:0]  i_bus_id,
  input  wire logic [2:0]  i_bus_tag,
  input  wire logic [3:0]  i_bus_data_hi,
  input  wire logic [3:0]  i_bus_mask,
  input  wire logic [1:0]  i_bus_confirm,
  input  wire logic [15:0] i_bus_xmit_req,
  // bus interface events
  input  wire logic        i_crd_event,
  input  wire logic        i_rds_event,
  input  wire logic        i_cp_timeout,
  input  wire logic [1:0]  i_cp_timeout_code,
  input  wire logic        i_cp_err_confirm,
  input  wire logic        i_bus_idle,
  output logic             o_bus_irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic        we_g0;
    logic        we_g1;
    logic [31:0] pte;
    logic [20:0] ctl0;
    logic [20:0] st1;
    logic [3:0]  silo_ptr;
    logic        after_fault;
    logic [15:0] err;
    logic [6:0]  lfsr;
    logic        irq;
    logic [2:0]  fault_sync;
    logic        fault;
    logic [11:0] par_err;
  } state_t;

  state_t       s_q;
  state_t       s_d;
  logic [31:0]  silo_mem [SILO_DEPTH];
  logic [31:0]  silo_entry;
  logic         fault_now;
  logic         wr_port;
  logic         wr_c0;
  logic         wr_s1;
  logic         wr_be;
  logic         rd_silo;
  logic         cp_err_any;
  logic [11:0]  par_mask;
  logic [3:0]   par_code;

  assign fault_now  = s_q.fault;
  // forced miss hides that group's parity checkers
  assign par_mask   = {{3{s_q.ctl0[C0_MISS_G1]}}, {3{s_q.ctl0[C0_MISS_G0]}},
                       {3{s_q.ctl0[C0_MISS_G1]}}, {3{s_q.ctl0[C0_MISS_G0]}}};
  assign wr_port    = i_reg_wr && i_reg_addr == ADDR_TRANSLATION_WRITE_PORT;
  assign wr_c0      = i_reg_wr && i_reg_addr == ADDR_TRANSLATION_CONTROL_0;
  assign wr_s1      = i_reg_wr && i_reg_addr == ADDR_TRANSLATION_STATUS_1;
  assign wr_be      = i_reg_wr && i_reg_addr == ADDR_BUS_ERROR_STATUS;
  assign rd_silo    = i_reg_rd && i_reg_addr == ADDR_BUS_HISTORY_SILO;
  assign cp_err_any = i_cp_timeout | i_cp_err_confirm;

  assign silo_entry = {s_q.after_fault, i_bus_interlock, i_bus_id, i_bus_tag,
                       (i_bus_tag == TAG_CMD_ADDR) ? i_bus_data_hi : i_bus_mask,
                       i_bus_confirm, i_bus_xmit_req};

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.fault_sync = {s_q.fault_sync[1:0], i_bus_fault};
    // fault level changes only once the last two stages agree
    if (s_q.fault_sync[2] == s_q.fault_sync[1]) begin
      s_d.fault = s_q.fault_sync[2];
    end
    s_d.lfsr = {s_q.lfsr[5:0], s_q.lfsr[6] ^ s_q.lfsr[5]};

    s_d.we_g0 = 1'b0;
    s_d.we_g1 = 1'b0;
    if (wr_port) begin
      s_d.pte = i_reg_wdata;
      if (s_q.ctl0[C0_REPL_BOTH]) begin
        s_d.we_g0 = 1'b1;
        s_d.we_g1 = 1'b1;
      end else if (i_g0_match) begin
        s_d.we_g0 = 1'b1;
      end else if (i_g1_match) begin
        s_d.we_g1 = 1'b1;
      end else if (s_q.ctl0[C0_REPL_LO +: 2] == REPL_G0) begin
        s_d.we_g0 = 1'b1;
      end else if (s_q.ctl0[C0_REPL_LO +: 2] == REPL_G1) begin
        s_d.we_g1 = 1'b1;
      end else begin
        s_d.we_g0 = ~s_q.lfsr[0];
        s_d.we_g1 = s_q.lfsr[0];
      end
    end

    // control register zero
    if (wr_c0) begin
      s_d.ctl0 = (s_q.ctl0 & ~C0_WR_MASK) | (i_reg_wdata[20:0] & C0_WR_MASK);
    end
    s_d.ctl0[C0_G0_MATCH] = i_g0_match;
    s_d.ctl0[C0_G1_MATCH] = i_g1_match;
    if (i_mem_req) begin
      s_d.ctl0[C0_LAST_LO +: 8] = i_mem_req_info;
    end
    // forced parity decode: bits 0-5 address, 6-11 data, as status order
    par_code = s_d.ctl0[C0_PAR_LO +: 4];
    s_d.par_err = 12'h000;
    if (par_code >= FPE_G0_DATA && par_code < FPE_G1_DATA) begin
      s_d.par_err[6 + 32'(par_code - FPE_G0_DATA)] = 1'b1;
    end else if (par_code >= FPE_G1_DATA && par_code < FPE_G0_ADDR) begin
      s_d.par_err[9 + 32'(par_code - FPE_G1_DATA)] = 1'b1;
    end else if (par_code >= FPE_G0_ADDR && par_code < FPE_G1_ADDR) begin
      s_d.par_err[32'(par_code - FPE_G0_ADDR)] = 1'b1;
    end else if (par_code >= FPE_G1_ADDR && par_code < 4'hE) begin
      s_d.par_err[3 + 32'(par_code - FPE_G1_ADDR)] = 1'b1;
    end

    // status register one
    if (wr_s1) begin
      // write clears trap flag and parity bits
      s_d.st1[S1_PAR_TRAP] = 1'b0;
      s_d.st1[S1_PAR_LO +: 12] = 12'h000;
    end
    if (i_par_err && (i_par_traps_on || i_pfa_load)) begin
      s_d.st1[S1_PAR_LO +: 12] = i_par_checkers & ~par_mask;
    end
    if (i_par_trap_req) begin
      s_d.st1[S1_PAR_TRAP] = 1'b1;
    end
    if (i_pfa_load) begin
      s_d.st1[S1_INFO_LO +: 4] = i_pfa_info;
    end
    if (i_pfa_cross_page || i_flush) begin
      s_d.st1[S1_BAD_PFA] = 1'b1;
    end else if (i_pfa_load) begin
      s_d.st1[S1_BAD_PFA] = 1'b0;
    end
    if (s_q.we_g0 ^ s_q.we_g1) begin
      s_d.st1[S1_LAST_GRP] = s_q.we_g1;
    end

    if (!fault_now) begin
      s_d.silo_ptr = s_q.silo_ptr + 4'h1;
      s_d.after_fault = 1'b0;
    end else begin
      s_d.after_fault = 1'b1;
      if (rd_silo) begin
        s_d.silo_ptr = s_q.silo_ptr + 4'h1;
      end
    end

    // bus error register
    if (wr_be) begin
      s_d.err[BE_INT_EN] = i_reg_wdata[BE_INT_EN];
      if (i_reg_wdata[BE_CRD]) s_d.err[BE_CRD] = 1'b0;
      if (i_reg_wdata[BE_RDS]) s_d.err[BE_RDS] = 1'b0;
      if (i_reg_wdata[BE_TIMEOUT]) begin
        s_d.err[BE_TIMEOUT] = 1'b0;
        s_d.err[BE_TO_LO +: 2] = 2'h0;
        s_d.err[BE_ERR_CNF] = 1'b0;
        s_d.err[BE_MULTI] = 1'b0;
      end
    end
    if (i_crd_event) s_d.err[BE_CRD] = 1'b1;
    if (i_rds_event) s_d.err[BE_RDS] = 1'b1;
    if (cp_err_any && (s_q.err[BE_TIMEOUT] || s_q.err[BE_ERR_CNF])) begin
      s_d.err[BE_MULTI] = 1'b1;
    end
    if (i_cp_timeout) begin
      s_d.err[BE_TIMEOUT] = 1'b1;
      s_d.err[BE_TO_LO +: 2] = i_cp_timeout_code;
    end
    if (i_cp_err_confirm) s_d.err[BE_ERR_CNF] = 1'b1;
    s_d.err[BE_NOT_BUSY] = i_bus_idle;
    s_d.irq = (s_q.err[BE_INT_EN] & (s_q.err[BE_CRD] | s_q.err[BE_RDS]))
            | s_q.err[BE_TIMEOUT] | s_q.err[BE_ERR_CNF];

    // read data, write-only port reads zero
    unique case (i_reg_addr)
      ADDR_TRANSLATION_CONTROL_0: s_d.rdata = {11'h000, s_q.ctl0};
      ADDR_TRANSLATION_STATUS_1:  s_d.rdata = {11'h000, s_q.st1};
      ADDR_BUS_HISTORY_SILO:      s_d.rdata = silo_mem[s_q.silo_ptr];
      ADDR_BUS_ERROR_STATUS:      s_d.rdata = {16'h0000, s_q.err};
      default:                    s_d.rdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.lfsr <= 7'h01;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!fault_now) begin
      silo_mem[s_q.silo_ptr] <= silo_entry;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign o_reg_rdata      = s_q.rdata;
  assign o_tb_we_g0       = s_q.we_g0;
  assign o_tb_we_g1       = s_q.we_g1;
  assign o_tb_pte         = s_q.pte;
  // mapping enable steers traps and translation
  assign o_mapping_enable = s_q.ctl0[C0_MAP_EN];
  assign o_force_miss_g0  = s_q.ctl0[C0_MISS_G0];
  assign o_force_miss_g1  = s_q.ctl0[C0_MISS_G1];
  assign o_bus_irq        = s_q.irq;
  assign o_force_par_err  = s_q.par_err;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_write_both;
    wr_port && s_q.ctl0[C0_REPL_BOTH];
  endsequence

  chk_repl_both_write: assert property (s_write_both |=> o_tb_we_g0 && o_tb_we_g1)
    else $error("replace-both write missed a group");
  chk_forced_group: assert property (wr_port && !s_q.ctl0[C0_REPL_BOTH] && !i_g0_match
      && !i_g1_match && s_q.ctl0[C0_REPL_LO +: 2] == REPL_G1 |=> o_tb_we_g1 && !o_tb_we_g0)
    else $error("forced group one not honoured");
  chk_hit_group: assert property (wr_port && !s_q.ctl0[C0_REPL_BOTH] && i_g0_match
      |=> o_tb_we_g0 && !o_tb_we_g1)
    else $error("hit group not updated");
  chk_silo_frozen: assert property (fault_now && !rd_silo |=> $stable(s_q.silo_ptr))
    else $error("silo pointer moved during fault");
  chk_silo_advance: assert property (!fault_now |=> s_q.silo_ptr == $past(s_q.silo_ptr) + 4'h1)
    else $error("silo pointer did not advance");
  chk_timeout_clear: assert property (wr_be && i_reg_wdata[BE_TIMEOUT] && !cp_err_any
      |=> !s_q.err[BE_TIMEOUT] && !s_q.err[BE_MULTI] && !s_q.err[BE_ERR_CNF])
    else $error("timeout group not cleared");
  chk_timeout_irq: assert property (s_q.err[BE_TIMEOUT] |=> o_bus_irq)
    else $error("timeout without interrupt");
  chk_multi_error: assert property (cp_err_any && s_q.err[BE_ERR_CNF] |=> s_q.err[BE_MULTI])
    else $error("second error not flagged");
  chk_bad_pfa_clear: assert property (i_pfa_load && !i_flush && !i_pfa_cross_page
      |=> !s_q.st1[S1_BAD_PFA])
    else $error("prefetch invalid not cleared on load");

endmodule : tb_diag_regs

`default_nettype wire

// >>> logic/tb_diag_pkg.sv
/*
  constants for the translation-buffer and backplane-bus diagnostic register set:
  internal bus register addresses, field positions and encodings.
  assumes one cpu clock at 25 MHz and an 8-bit internal bus register address.
*/
`default_nettype none

package tb_diag_pkg;

  // --------------------------------------------------------------------------
  // register addresses on the internal data bus
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TRANSLATION_WRITE_PORT = 8'h10;
  localparam logic [7:0] ADDR_TRANSLATION_CONTROL_0  = 8'h12;
  localparam logic [7:0] ADDR_TRANSLATION_STATUS_1   = 8'h13;
  localparam logic [7:0] ADDR_BUS_HISTORY_SILO       = 8'h18;
  localparam logic [7:0] ADDR_BUS_ERROR_STATUS       = 8'h19;

  // --------------------------------------------------------------------------
  // control register zero fields
  // --------------------------------------------------------------------------
  localparam int C0_MAP_EN     = 0;
  localparam int C0_PAR_LO     = 1;
  localparam int C0_G0_MATCH   = 6;
  localparam int C0_G1_MATCH   = 7;
  localparam int C0_LAST_LO    = 8;
  localparam int C0_MISS_G0    = 16;
  localparam int C0_MISS_G1    = 17;
  localparam int C0_REPL_LO    = 18;
  localparam int C0_REPL_BOTH  = 20;
  localparam logic [20:0] C0_WR_MASK  = 21'h1F001F;
  localparam logic [1:0]  REPL_RANDOM = 2'h0;
  localparam logic [1:0]  REPL_G0     = 2'h1;
  localparam logic [1:0]  REPL_G1     = 2'h2;

  // forced parity codes: base of each run of three checkers
  localparam logic [3:0] FPE_G0_DATA = 4'h2;
  localparam logic [3:0] FPE_G1_DATA = 4'h5;
  localparam logic [3:0] FPE_G0_ADDR = 4'h8;
  localparam logic [3:0] FPE_G1_ADDR = 4'hB;

  // --------------------------------------------------------------------------
  // status register one fields
  // --------------------------------------------------------------------------
  localparam int S1_INFO_LO    = 0;
  localparam int S1_BAD_PFA    = 4;
  localparam int S1_LAST_GRP   = 6;
  localparam int S1_PAR_TRAP   = 8;
  localparam int S1_PAR_LO     = 9;

  // --------------------------------------------------------------------------
  // silo fields
  // --------------------------------------------------------------------------
  localparam int SILO_DEPTH    = 16;
  localparam int SILO_FIRST    = 31;
  localparam logic [2:0] TAG_CMD_ADDR = 3'h0;

  // --------------------------------------------------------------------------
  // bus error register fields
  // --------------------------------------------------------------------------
  localparam int BE_INT_EN     = 15;
  localparam int BE_CRD        = 14;
  localparam int BE_RDS        = 13;
  localparam int BE_TIMEOUT    = 12;
  localparam int BE_TO_LO      = 10;
  localparam int BE_ERR_CNF    = 8;
  localparam int BE_MULTI      = 2;
  localparam int BE_NOT_BUSY   = 1;

endpackage : tb_diag_pkg

`default_nettype wire

// >>> sim/cpu_datapath_model.sv
/*
  behavioural model of the microcoded data path on the internal data bus.
  assumes strobes are taken on the rising edge and read data is registered.
*/
`default_nettype none

module cpu_datapath_model
  import tb_diag_pkg::*;
(
  // clock
  input  wire logic        i_clk,
  // register access
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [7:0]  o_reg_addr,
  output logic      [31:0] o_reg_wdata,
  input  wire logic [31:0] i_reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 32'h0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (a == ADDR_TRANSLATION_CONTROL_0 && d[19:18] == 2'h3) begin
      v[19:18] = REPL_RANDOM;
    end
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_wdata = v;
    o_reg_wr = 1'b1;
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    o_reg_wdata = ~v;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clk);
    d = i_reg_rdata;
    o_reg_rd = 1'b0;
  endtask : read_reg

endmodule : cpu_datapath_model

`default_nettype wire

// >>> sim/tb_diag_regs_tb.sv
/*
  self-checking bench for tb_diag_regs, register traffic through the data path model.
  assumes a 25 MHz clock; every input changes at the falling edge.
*/
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_diag_regs_tb;
  import tb_diag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_n, wr, rd, g0m, g1m, mreq, pld, xpg, fls, ptrap, perr, pon;
  logic        flt, ilk, corrected_read_data, read_data_substitute, cto, ecf, idle, we0, we1, men, ms0, ms1, irq;
  logic [7:0]  addr, minfo;
  logic [31:0] wdat, rdat, rv, pte;
  logic [11:0] fpe, pchk;
  logic [3:0]  pinfo, dhi, msk;
  logic [4:0]  bid;
  logic [2:0]  tag;
  logic [1:0]  cnf, tcode;
  logic [15:0] xr;
  int          fail_count, num_checks;

  cpu_datapath_model u_cpu (.i_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdat), .i_reg_rdata(rdat));

  tb_diag_regs u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat), .i_g0_match(g0m),
    .i_g1_match(g1m), .o_tb_we_g0(we0), .o_tb_we_g1(we1), .o_tb_pte(pte),
    .o_mapping_enable(men), .o_force_miss_g0(ms0), .o_force_miss_g1(ms1),
    .o_force_par_err(fpe), .i_mem_req(mreq), .i_mem_req_info(minfo), .i_pfa_load(pld),
    .i_pfa_info(pinfo), .i_pfa_cross_page(xpg), .i_flush(fls), .i_par_trap_req(ptrap),
    .i_par_err(perr), .i_par_traps_on(pon), .i_par_checkers(pchk), .i_bus_fault(flt),
    .i_bus_interlock(ilk), .i_bus_id(bid), .i_bus_tag(tag), .i_bus_data_hi(dhi),
    .i_bus_mask(msk), .i_bus_confirm(cnf), .i_bus_xmit_req(xr), .i_crd_event(corrected_read_data),
    .i_rds_event(read_data_substitute), .i_cp_timeout(cto), .i_cp_timeout_code(tcode),
    .i_cp_err_confirm(ecf), .i_bus_idle(idle), .o_bus_irq(irq));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_ctl0;
    logic [11:0] e;
    `CHK("irq rst", 1'b0, irq)
    u_cpu.read_reg(ADDR_TRANSLATION_WRITE_PORT, rv);
    `CHK("port read", 32'h0, rv)
    u_cpu.write_reg(ADDR_TRANSLATION_CONTROL_0, 32'hFFF3FFFF);
    `CHK("miss", 3'h7, {men, ms0, ms1})
    u_cpu.read_reg(ADDR_TRANSLATION_CONTROL_0, rv);
    `CHK("ctl0", 21'h13001F, rv[20:0])
    for (int c = 0; c < 16; c++) begin
      u_cpu.write_reg(ADDR_TRANSLATION_CONTROL_0, {27'h0, c[3:0], 1'b0});
      e = 12'h0;
      if (c >= 2 && c <= 7) e[c + 4] = 1'b1;
      else if (c >= 8 && c <= 13) e[c - 8] = 1'b1;
      `CHK("par code", e, fpe)
    end
    `CHK("map off", 1'b0, men)
  endtask : t_ctl0

  task automatic t_tbwrite;
    int n;
    n = 0;
    u_cpu.write_reg(ADDR_TRANSLATION_CONTROL_0, 32'h00100000);
    u_cpu.write_reg(ADDR_TRANSLATION_WRITE_PORT, 32'h12345678);
    `CHK("we both", 2'h3, {we0, we1})
    `CHK("pte", 32'h12345678, pte)
    u_cpu.write_reg(ADDR_TRANSLATION_CONTROL_0, 32'(REPL_G1) << C0_REPL_LO);
    u_cpu.write_reg(ADDR_TRANSLATION_WRITE_PORT, 32'h0000ABCD);
    `CHK("we g1", 2'h1, {we0, we1})
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("last grp1", 1'b1, rv[S1_LAST_GRP])
    g0m = 1'b1;
    u_cpu.write_reg(ADDR_TRANSLATION_WRITE_PORT, 32'h00000F0F);
    `CHK("we hit", 2'h2, {we0, we1})
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("last grp0", 1'b0, rv[S1_LAST_GRP])
    g0m = 1'b0;
    g1m = 1'b1;
    u_cpu.write_reg(ADDR_TRANSLATION_CONTROL_0, 32'(REPL_G0) << C0_REPL_LO);
    u_cpu.write_reg(ADDR_TRANSLATION_WRITE_PORT, 32'h00000F0F);
    `CHK("we hit1", 2'h1, {we0, we1})
    g1m = 1'b0;
    u_cpu.write_reg(ADDR_TRANSLATION_WRITE_PORT, 32'h00000F0F);
    `CHK("we g0", 2'h2, {we0, we1})
    u_cpu.write_reg(ADDR_TRANSLATION_CONTROL_0, 32'h0);
    for (int i = 0; i < 16; i++) begin
      u_cpu.write_reg(ADDR_TRANSLATION_WRITE_PORT, 32'h00000100);
      `CHK("we rand", 1'b1, we0 ^ we1)
      n += int'(we1);
    end
    `CHK("rand mix", 1'b1, n > 0 && n < 16)
  endtask : t_tbwrite

  task automatic t_status;
    minfo = 8'hA5;
    g1m = 1'b1;
    pulse(mreq);
    u_cpu.read_reg(ADDR_TRANSLATION_CONTROL_0, rv);
    `CHK("last ref", 8'hA5, rv[15:8])
    `CHK("hits", 2'h2, rv[7:6])
    g1m = 1'b0;
    pinfo = 4'h9;
    pulse(xpg);
    pulse(pld);
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("pfa info", 5'h09, rv[4:0])
    pulse(fls);
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("pfa bad", 1'b1, rv[S1_BAD_PFA])
    pchk = 12'h0F0;
    pulse(perr);
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("par off", 13'h0, rv[20:8])
    pon = 1'b1;
    pchk = 12'hA5C;
    pulse(ptrap);
    pulse(perr);
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("par on", {12'hA5C, 1'b1}, rv[20:8])
    u_cpu.write_reg(ADDR_TRANSLATION_STATUS_1, 32'h0);
    u_cpu.read_reg(ADDR_TRANSLATION_STATUS_1, rv);
    `CHK("par clr", 13'h0, rv[20:8])
  endtask : t_status

  task automatic t_silo;
    int n;
    n = 0;
    {ilk, bid, tag, dhi, msk, cnf, xr} = {1'b1, 5'h15, TAG_CMD_ADDR, 4'h9, 4'h6, 2'h2, 16'hC3A5};
    repeat (20) @(negedge clk);
    flt = 1'b1;
    repeat (6) @(negedge clk);
    {ilk, bid, tag, cnf, xr} = {1'b0, 5'h0A, 3'h3, 2'h1, 16'h5A3C};
    for (int i = 0; i < SILO_DEPTH; i++) begin
      u_cpu.read_reg(ADDR_BUS_HISTORY_SILO, rv);
      `CHK("silo cmd", {1'b1, 5'h15, 3'h0, 4'h9, 2'h2, 16'hC3A5}, rv[30:0])
    end
    flt = 1'b0;
    repeat (8) @(negedge clk);
    flt = 1'b1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < SILO_DEPTH; i++) begin
      u_cpu.read_reg(ADDR_BUS_HISTORY_SILO, rv);
      if (rv[SILO_FIRST] === 1'b1) begin
        n++;
        `CHK("silo mask", {1'b0, 5'h0A, 3'h3, 4'h6, 2'h1, 16'h5A3C}, rv[30:0])
      end
    end
    `CHK("first marks", 1, n)
    flt = 1'b0;
  endtask : t_silo

  task automatic t_buserr;
    u_cpu.write_reg(ADDR_BUS_ERROR_STATUS, 32'h8000);
    pulse(corrected_read_data);
    u_cpu.read_reg(ADDR_BUS_ERROR_STATUS, rv);
    `CHK("crd", 4'hD, {rv[15:13], rv[BE_NOT_BUSY]})
    `CHK("irq crd", 1'b1, irq)
    u_cpu.write_reg(ADDR_BUS_ERROR_STATUS, 32'h4000);
    pulse(read_data_substitute);
    u_cpu.read_reg(ADDR_BUS_ERROR_STATUS, rv);
    `CHK("rds", 3'h1, rv[15:13])
    `CHK("irq off", 1'b0, irq)
    u_cpu.write_reg(ADDR_BUS_ERROR_STATUS, 32'h2000);
    for (int c = 0; c < 3; c++) begin
      tcode = c[1:0];
      pulse(cto);
      u_cpu.read_reg(ADDR_BUS_ERROR_STATUS, rv);
      `CHK("timeout", {1'b1, c[1:0]}, rv[12:10])
      `CHK("irq to", 1'b1, irq)
      u_cpu.write_reg(ADDR_BUS_ERROR_STATUS, 32'h1000);
    end
    pulse(ecf);
    u_cpu.read_reg(ADDR_BUS_ERROR_STATUS, rv);
    `CHK("err cnf", 6'h01, {rv[12:8], rv[BE_MULTI]} >> 1)
    `CHK("irq cnf", 1'b1, irq)
    tcode = 2'h1;
    pulse(cto);
    idle = 1'b0;
    u_cpu.read_reg(ADDR_BUS_ERROR_STATUS, rv);
    `CHK("multi", 7'h56, {rv[12:8], rv[2:1]})
    u_cpu.write_reg(ADDR_BUS_ERROR_STATUS, 32'h1000);
    u_cpu.read_reg(ADDR_BUS_ERROR_STATUS, rv);
    `CHK("err clr", 16'h0, rv[15:0])
    `CHK("irq clr", 1'b0, irq)
  endtask : t_buserr

  // --------------------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    fail_count = 0;
    num_checks = 0;
    {rst_n, g0m, g1m, mreq, pld, xpg, fls, ptrap, perr, pon, flt} = 11'h0;
    {ilk, corrected_read_data, read_data_substitute, cto, ecf, minfo, pinfo, pchk, tcode} = 31'h0;
    {bid, tag, dhi, msk, cnf, xr} = 34'h0;
    idle = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_ctl0;
    t_tbwrite;
    t_status;
    t_silo;
    t_buserr;
    test_done;
  end

  initial begin
    repeat (10000) @(posedge clk);
    fail_count++;
    test_done;
  end

endmodule : tb_diag_regs_tb

`undef CHK
`default_nettype wire
